//--- logic/uhls_fifo.sv
// Small valid/ready FIFO carrying packet data towards the serial engine.
// Assumes one clock and an active-low asynchronous reset.
`timescale 1ns/1ps
module uhls_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 4
) (
    // Clock and reset
    input  wire logic             ref_clk_i,
    input  wire logic             rst_n_i,
    // Fill side
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    // Drain side
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic [WIDTH-1:0]      out_data_o
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wr;
        logic [AW-1:0]               rd;
        logic [AW:0]                 cnt;
    } uhls_fifo_st_t;

    uhls_fifo_st_t s_q;
    uhls_fifo_st_t s_d;
    logic          push;
    logic          pop;

    // Honest full and empty from the count
    assign in_ready_o  = (s_q.cnt != (AW+1)'(DEPTH));
    assign out_valid_o = (s_q.cnt != '0);
    assign out_data_o  = s_q.mem[s_q.rd];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    // Next state
    always_comb begin
        s_d = s_q;
        if (push) begin
            s_d.mem[s_q.wr] = in_data_i;
            s_d.wr          = s_q.wr + 1'b1;
        end
        if (pop) begin
            s_d.rd = s_q.rd + 1'b1;
        end
        s_d.cnt = s_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    // State register
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

endmodule : uhls_fifo

//--- logic/uhls_map.svh
// Constants for the list scheduler: shared-area layout, timing, limits.
// Assumes a 200 MHz reference clock and a 32-bit memory bus.
`ifndef UHLS_MAP_SVH
`define UHLS_MAP_SVH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define UHLS_CLK_PERIOD_PS   5000
`define UHLS_FRAME_US        1000
`define UHLS_FRAME_CYC       ((`UHLS_FRAME_US * 1000 * 1000) / `UHLS_CLK_PERIOD_PS)

// ----------------------------------------------------------------
// Shared communication area layout (byte offsets)
// ----------------------------------------------------------------
`define UHLS_AREA_INT_TABLE  32'h0000_0000
`define UHLS_AREA_FRAME_NUM  32'h0000_0080
`define UHLS_AREA_DONE_HEAD  32'h0000_0084
`define UHLS_INT_LISTS       32
`define UHLS_INT_IDX_BITS    5

// ----------------------------------------------------------------
// Descriptor layout (byte offsets, field positions)
// ----------------------------------------------------------------
`define UHLS_ED_CTRL         32'h0000_0000
`define UHLS_ED_TD_HEAD      32'h0000_0008
`define UHLS_ED_NEXT         32'h0000_000C
`define UHLS_TD_CTRL         32'h0000_0000
`define UHLS_TD_BUF_CUR      32'h0000_0004
`define UHLS_TD_NEXT         32'h0000_0008
`define UHLS_TD_BUF_END      32'h0000_000C
`define UHLS_ED_FA_LSB       0
`define UHLS_ED_EN_LSB       7
`define UHLS_ED_DIR_LSB      11
`define UHLS_ED_SPEED_BIT    13
`define UHLS_ED_MPS_LSB      16
`define UHLS_TD_TOGGLE_LSB   24
`define UHLS_TD_CC_LSB       28
`define UHLS_PAGE_BITS       12
`define UHLS_TD_MAX_BYTES    8192
`define UHLS_PTR_MASK        32'hFFFF_FFF0
`define UHLS_NULL_PTR        32'h0000_0000

// ----------------------------------------------------------------
// Reset values, port count and FIFO depth
// ----------------------------------------------------------------
`define UHLS_CB_RATIO_RST    2'h3
`define UHLS_ROOT_PORTS      3
`define UHLS_FIFO_DEPTH      4

`endif

//--- logic/uhls_pkg.sv
// Types for the list scheduler.
// Assumes uhls_map.svh is on the include path.
package uhls_pkg;

    // ------------------------------------------------------------
    // Scheduler states
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        UHLS_IDLE      = 4'b0000,
        UHLS_SOF       = 4'b0001,
        UHLS_FN_WR     = 4'b0010,
        UHLS_PICK      = 4'b0011,
        UHLS_ED_RD     = 4'b0100,
        UHLS_TD_RD     = 4'b0101,
        UHLS_XFER      = 4'b0110,
        UHLS_RETIRE    = 4'b0111,
        UHLS_DONE_WR   = 4'b1000,
        UHLS_INT_RD    = 4'b1001,
        UHLS_WAIT_EOF  = 4'b1010
    } uhls_state_t;

    // List being served
    typedef enum logic [1:0] {
        UHLS_L_CTRL = 2'b00,
        UHLS_L_BULK = 2'b01,
        UHLS_L_PER  = 2'b10
    } uhls_list_t;

    // Bus transfer phases
    typedef enum logic [1:0] {
        UHLS_PH_REQ  = 2'b00,
        UHLS_PH_WAIT = 2'b01
    } uhls_phase_t;

endpackage : uhls_pkg

//--- logic/uhls_sched.sv
// List processor: frame timer, list walker, memory master, packet request.
// Assumes the serial engine takes packet requests and reports completion.
`timescale 1ns/1ps
`include "uhls_map.svh"
module uhls_sched (
    // Clock and reset
    input  wire logic                 ref_clk_i,
    input  wire logic                 rst_n_i,
    // Software settings (level, same clock)
    input  wire logic                 run_i,
    input  wire logic                 ctrl_en_i,
    input  wire logic                 bulk_en_i,
    input  wire logic                 per_en_i,
    input  wire logic [1:0]           cb_ratio_i,
    input  wire logic [31:0]          area_base_i,
    input  wire logic [31:0]          ctrl_head_i,
    input  wire logic [31:0]          bulk_head_i,
    input  wire logic [13:0]          per_start_i,
    // Memory master
    output logic                      mem_req_o,
    output logic                      mem_we_o,
    output logic [31:0]               mem_addr_o,
    output logic [31:0]               mem_wdata_o,
    input  wire logic                 mem_ack_i,
    input  wire logic [31:0]          mem_rdata_i,
    // Packet engine
    output logic                      sof_o,
    output logic                      pkt_req_o,
    output logic [6:0]                pkt_addr_o,
    output logic [3:0]                pkt_ep_o,
    output logic [1:0]                pkt_dir_o,
    output logic                      pkt_low_o,
    output logic [10:0]               pkt_mps_o,
    output logic                      pkt_toggle_o,
    output logic [1:0]                pkt_port_o,
    input  wire logic                 pkt_done_i,
    input  wire logic [3:0]           pkt_cc_i,
    // Packet data stream
    output logic                      dat_valid_o,
    input  wire logic                 dat_ready_i,
    output logic [31:0]               dat_o,
    // Status
    output logic [15:0]               frame_num_o,
    output logic [31:0]               done_head_o
);
    import uhls_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        uhls_state_t st;
        uhls_phase_t ph;
        uhls_list_t  lst;
        logic        per_done;
        logic [17:0] fcnt;
        logic [15:0] fnum;
        logic [31:0] ctrl_cur;
        logic [31:0] bulk_cur;
        logic [31:0] ed;
        logic [31:0] ed_ctrl;
        logic [31:0] ed_next;
        logic [31:0] td;
        logic [31:0] td_ctrl;
        logic [31:0] td_next;
        logic [31:0] buf_cur;
        logic [1:0]  cb_cnt;
        logic [2:0]  wi;
        logic [31:0] done_head;
        logic        mreq;
        logic        mwe;
        logic [31:0] maddr;
        logic [31:0] mwdata;
        logic        sof;
        logic        preq;
        logic        dval;
    } uhls_st_t;

    uhls_st_t s_q;
    uhls_st_t s_d;
    logic     fifo_ready;
    logic     ack;

    assign ack = s_q.mreq && mem_ack_i;

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        logic [31:0] nxt;
        logic        frame_end;
        nxt       = '0;
        frame_end = (s_q.fcnt == 18'(`UHLS_FRAME_CYC - 1));
        s_d       = s_q;
        s_d.sof   = 1'b0;
        s_d.dval  = 1'b0;
        // Frame timer, 1 ms at 200 MHz
        s_d.fcnt = frame_end ? '0 : s_q.fcnt + 1'b1;
        case (s_q.st)
            UHLS_IDLE: begin
                // Entering operation opens a frame at once
                if (run_i) begin
                    s_d.st   = UHLS_SOF;
                    s_d.fcnt = '0;
                end
            end
            UHLS_SOF: begin
                s_d.sof      = 1'b1;
                s_d.fnum     = s_q.fnum + 1'b1;
                s_d.per_done = !per_en_i;
                s_d.st       = UHLS_FN_WR;
                s_d.mreq     = 1'b1;
                s_d.mwe      = 1'b1;
                s_d.maddr    = area_base_i + `UHLS_AREA_FRAME_NUM;
                s_d.mwdata   = {16'h0000, s_q.fnum + 16'h0001};
            end
            UHLS_FN_WR: begin
                if (ack) begin
                    s_d.mreq = 1'b0;
                    s_d.st   = UHLS_PICK;
                end
            end
            UHLS_PICK: begin
                // Periodic once threshold passes, else non-periodic
                if (!run_i) begin
                    s_d.st = UHLS_IDLE;
                end else if (!s_q.per_done && s_q.fcnt >= {4'h0, per_start_i}) begin
                    s_d.lst   = UHLS_L_PER;
                    s_d.st    = UHLS_INT_RD;
                    s_d.mreq  = 1'b1;
                    s_d.mwe   = 1'b0;
                    s_d.maddr = area_base_i + `UHLS_AREA_INT_TABLE
                              + {25'h0, s_q.fnum[`UHLS_INT_IDX_BITS-1:0], 2'b00};
                end else if (ctrl_en_i && (s_q.cb_cnt <= cb_ratio_i || !bulk_en_i)) begin
                    s_d.lst   = UHLS_L_CTRL;
                    s_d.ed    = (s_q.ctrl_cur == `UHLS_NULL_PTR) ? ctrl_head_i : s_q.ctrl_cur;
                    s_d.st    = UHLS_ED_RD;
                    s_d.wi    = 3'h0;
                end else if (bulk_en_i) begin
                    s_d.lst   = UHLS_L_BULK;
                    s_d.ed    = (s_q.bulk_cur == `UHLS_NULL_PTR) ? bulk_head_i : s_q.bulk_cur;
                    s_d.st    = UHLS_ED_RD;
                    s_d.wi    = 3'h0;
                end else begin
                    s_d.st = UHLS_WAIT_EOF;
                end
            end
            UHLS_INT_RD: begin
                if (ack) begin
                    s_d.mreq = 1'b0;
                    s_d.ed   = mem_rdata_i & `UHLS_PTR_MASK;
                    s_d.wi   = 3'h0;
                    s_d.st   = ((mem_rdata_i & `UHLS_PTR_MASK) == `UHLS_NULL_PTR) ?
                               UHLS_PICK : UHLS_ED_RD;
                    s_d.per_done = ((mem_rdata_i & `UHLS_PTR_MASK) == `UHLS_NULL_PTR);
                end
            end
            UHLS_ED_RD: begin
                // Fetch control, TD head and next words of the endpoint
                if (s_q.ed == `UHLS_NULL_PTR) begin
                    s_d.st = UHLS_PICK;
                    if (s_q.lst == UHLS_L_PER) begin
                        s_d.per_done = 1'b1;
                    end
                    // Empty bulk list still hands the turn back to control
                    if (s_q.lst == UHLS_L_BULK) begin
                        s_d.cb_cnt = 2'h0;
                    end
                end else if (!s_q.mreq) begin
                    s_d.mreq  = 1'b1;
                    s_d.mwe   = 1'b0;
                    s_d.maddr = s_q.ed + ((s_q.wi == 3'h0) ? `UHLS_ED_CTRL :
                                (s_q.wi == 3'h1) ? `UHLS_ED_TD_HEAD : `UHLS_ED_NEXT);
                end else if (ack) begin
                    s_d.mreq = 1'b0;
                    s_d.wi   = s_q.wi + 1'b1;
                    if (s_q.wi == 3'h0) begin
                        s_d.ed_ctrl = mem_rdata_i;
                    end else if (s_q.wi == 3'h1) begin
                        s_d.td = mem_rdata_i & `UHLS_PTR_MASK;
                    end else begin
                        s_d.ed_next = mem_rdata_i & `UHLS_PTR_MASK;
                        s_d.wi      = 3'h0;
                        s_d.st      = (s_q.td == `UHLS_NULL_PTR) ? UHLS_RETIRE : UHLS_TD_RD;
                    end
                end
            end
            UHLS_TD_RD: begin
                if (!s_q.mreq) begin
                    s_d.mreq  = 1'b1;
                    s_d.mwe   = 1'b0;
                    s_d.maddr = s_q.td + ((s_q.wi == 3'h0) ? `UHLS_TD_CTRL :
                                (s_q.wi == 3'h1) ? `UHLS_TD_BUF_CUR : `UHLS_TD_NEXT);
                end else if (ack) begin
                    s_d.mreq = 1'b0;
                    s_d.wi   = s_q.wi + 1'b1;
                    if (s_q.wi == 3'h0) begin
                        s_d.td_ctrl = mem_rdata_i;
                    end else if (s_q.wi == 3'h1) begin
                        s_d.buf_cur = mem_rdata_i;
                    end else begin
                        s_d.td_next = mem_rdata_i & `UHLS_PTR_MASK;
                        s_d.preq    = 1'b1;
                        s_d.st      = UHLS_XFER;
                    end
                end
            end
            UHLS_XFER: begin
                // Buffer pointer feeds the data stream whenever the FIFO has room
                if (fifo_ready) begin
                    s_d.dval = 1'b1;
                end
                if (pkt_done_i) begin
                    s_d.preq   = 1'b0;
                    s_d.wi     = 3'h0;
                    s_d.td_ctrl[`UHLS_TD_CC_LSB +: 4] = pkt_cc_i;
                    s_d.st     = UHLS_DONE_WR;
                end
            end
            UHLS_DONE_WR: begin
                // Write status, link to old done head, advance ED TD head, then new done head
                if (!s_q.mreq) begin
                    s_d.mreq  = 1'b1;
                    s_d.mwe   = 1'b1;
                    case (s_q.wi)
                        3'h0: begin
                            s_d.maddr  = s_q.td + `UHLS_TD_CTRL;
                            s_d.mwdata = s_q.td_ctrl;
                        end
                        3'h1: begin
                            s_d.maddr  = s_q.td + `UHLS_TD_NEXT;
                            s_d.mwdata = s_q.done_head;
                        end
                        3'h2: begin
                            s_d.maddr  = s_q.ed + `UHLS_ED_TD_HEAD;
                            s_d.mwdata = s_q.td_next;
                        end
                        default: begin
                            s_d.maddr  = area_base_i + `UHLS_AREA_DONE_HEAD;
                            s_d.mwdata = s_q.td;
                        end
                    endcase
                end else if (ack) begin
                    s_d.mreq = 1'b0;
                    s_d.wi   = s_q.wi + 1'b1;
                    if (s_q.wi == 3'h3) begin
                        s_d.done_head = s_q.td;
                        s_d.st        = UHLS_RETIRE;
                    end
                end
            end
            UHLS_RETIRE: begin
                // Advance along the endpoint list
                nxt    = s_q.ed_next;
                s_d.ed = nxt;
                s_d.wi = 3'h0;
                case (s_q.lst)
                    UHLS_L_CTRL: begin
                        s_d.ctrl_cur = nxt;
                        s_d.cb_cnt   = s_q.cb_cnt + 1'b1;
                        s_d.st       = UHLS_PICK;
                    end
                    UHLS_L_BULK: begin
                        s_d.bulk_cur = nxt;
                        s_d.cb_cnt   = 2'h0;
                        s_d.st       = UHLS_PICK;
                    end
                    default: begin
                        s_d.st = UHLS_ED_RD;
                    end
                endcase
            end
            UHLS_WAIT_EOF: begin
                s_d.st = run_i ? UHLS_PICK : UHLS_IDLE;
            end
            default: begin
                s_d.st = UHLS_IDLE;
            end
        endcase
        // Frame boundary opens with SOF while run_i is high, unless idle, in XFER or with a bus request pending
        if (frame_end && run_i && s_q.st != UHLS_IDLE && s_q.st != UHLS_XFER && !s_q.mreq) begin
            s_d.st = UHLS_SOF;
        end
        if (!ctrl_en_i) begin
            s_d.ctrl_cur = `UHLS_NULL_PTR;
        end
        if (!bulk_en_i) begin
            s_d.bulk_cur = `UHLS_NULL_PTR;
        end
    end

    // State register
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_q        <= '0;
            s_q.cb_cnt <= 2'h0;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // Packet data buffer
    // ------------------------------------------------------------
    uhls_fifo #(
        .WIDTH (32),
        .DEPTH (`UHLS_FIFO_DEPTH)
    ) u_fifo (
        .ref_clk_i   (ref_clk_i),
        .rst_n_i     (rst_n_i),
        .in_valid_i  (s_q.dval),
        .in_ready_o  (fifo_ready),
        .in_data_i   (s_q.buf_cur),
        .out_valid_o (dat_valid_o),
        .out_ready_i (dat_ready_i),
        .out_data_o  (dat_o)
    );

    // Outputs straight from state
    assign mem_req_o    = s_q.mreq;
    assign mem_we_o     = s_q.mwe;
    assign mem_addr_o   = s_q.maddr;
    assign mem_wdata_o  = s_q.mwdata;
    assign sof_o        = s_q.sof;
    assign pkt_req_o    = s_q.preq;
    assign pkt_addr_o   = s_q.ed_ctrl[`UHLS_ED_FA_LSB +: 7];
    assign pkt_ep_o     = s_q.ed_ctrl[`UHLS_ED_EN_LSB +: 4];
    assign pkt_dir_o    = s_q.ed_ctrl[`UHLS_ED_DIR_LSB +: 2];
    assign pkt_low_o    = s_q.ed_ctrl[`UHLS_ED_SPEED_BIT];
    assign pkt_mps_o    = s_q.ed_ctrl[`UHLS_ED_MPS_LSB +: 11];
    assign pkt_toggle_o = s_q.td_ctrl[`UHLS_TD_TOGGLE_LSB];
    assign pkt_port_o   = s_q.ed_ctrl[30:29];
    assign frame_num_o  = s_q.fnum;
    assign done_head_o  = s_q.done_head;

endmodule : uhls_sched

//--- tb/tb_uhls_sched.sv
// Self-checking bench for the list scheduler.
// Assumes the far-side model and the bound checker are compiled alongside.
`timescale 1ns/1ps
module tb_uhls_sched;
    logic ref_clk_i = 1'b0, rst_n_i = 1'b0, run_i = 1'b0;
    logic ctrl_en_i = 1'b1, bulk_en_i = 1'b1, per_en_i = 1'b1;
    logic [1:0]  cb_ratio_i = 2'h1;
    logic [31:0] area_base_i = 32'h0000_1000, ctrl_head_i = 32'h0000_2000;
    logic [31:0] bulk_head_i = 32'h0000_0000;
    logic [13:0] per_start_i = 14'h07D0;
    logic mem_req_o, mem_we_o, mem_ack_i, sof_o, pkt_req_o, pkt_low_o, pkt_toggle_o;
    logic pkt_done_i, dat_valid_o, dat_ready_i;
    logic [31:0] mem_addr_o, mem_wdata_o, mem_rdata_i, dat_o, done_head_o;
    logic [6:0]  pkt_addr_o;
    logic [3:0]  pkt_ep_o, pkt_cc_i;
    logic [1:0]  pkt_dir_o, pkt_port_o;
    logic [10:0] pkt_mps_o;
    logic [15:0] frame_num_o;
    int miscompares = 0, checks_done = 0, cyc = 0, n;

    uhls_sched uut (.*);
    uhls_far_model far (.ref_clk_i, .rst_n_i, .mem_req_i(mem_req_o), .mem_we_i(mem_we_o),
        .pkt_req_i(pkt_req_o), .mem_addr_i(mem_addr_o), .mem_wdata_i(mem_wdata_o),
        .mem_ack_o(mem_ack_i), .pkt_done_o(pkt_done_i), .dat_ready_o(dat_ready_i),
        .mem_rdata_o(mem_rdata_i), .pkt_cc_o(pkt_cc_i));

    initial begin
        forever #2.5 ref_clk_i = ~ref_clk_i;
    end
    // Cycle ceiling cuts a hang short
    always @(posedge ref_clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            miscompares++;
            wrap_up();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic wrap_up();
        if (miscompares == 0 && checks_done > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : wrap_up
    task automatic tick();
        @(posedge ref_clk_i);
        #1;
    endtask : tick

    // Outputs idle while reset is held
    task automatic t_reset();
        repeat (12) tick();
        check({mem_req_o, sof_o, pkt_req_o, dat_valid_o}, 32'h0);
        check(done_head_o, 32'h0);
        @(posedge ref_clk_i) rst_n_i <= 1'b1;
        @(posedge ref_clk_i) run_i <= 1'b1;
    endtask : t_reset
    // First frame start follows run at once
    task automatic t_frame();
        for (n = 0; n < 100 && sof_o !== 1'b1; n++) tick();
        check(n <= 3, 32'h1);
        tick();
        check(frame_num_o, 32'h1);
    endtask : t_frame
    // Two queued transfers: order, fields, retire and done queue
    task automatic t_xfer();
        for (n = 0; n < 20000 && pkt_req_o !== 1'b1; n++) tick();
        check({pkt_addr_o, pkt_ep_o, pkt_dir_o, pkt_low_o}, {7'h05, 4'h3, 2'h1, 1'b0});
        check({pkt_mps_o, pkt_port_o, pkt_toggle_o}, {11'h040, 2'h1, 1'b1});
        for (n = 0; n < 20000 && pkt_req_o !== 1'b0; n++) tick();
        for (n = 0; n < 20000 && pkt_req_o !== 1'b1; n++) tick();
        check(pkt_toggle_o, 32'h0);
        for (n = 0; n < 20000 && done_head_o !== 32'h0000_3010; n++) tick();
        repeat (50) tick();
        check(done_head_o, 32'h0000_3010);
        check(far.mem[32'h0000_3018], 32'h0000_3000);
        check(far.mem[32'h0000_3008], 32'h0000_0000);
        check(far.mem[32'h0000_1084], 32'h0000_3010);
        check(far.mem[32'h0000_2008], 32'h0000_0000);
        check(far.mem[32'h0000_3010][31:28], 32'h5);
        check(far.mem[32'h0000_1080][15:0], 32'h1);
        for (n = 0; n < 5000 && !(mem_req_o === 1'b1 && mem_we_o === 1'b0
            && mem_addr_o - area_base_i < 32'h0000_0080); n++) tick();
        check(mem_addr_o, 32'h0000_1004);
    endtask : t_xfer

    initial begin
        // Control endpoint with two transfers, empty bulk and interrupt lists
        // Interrupt heads left null: an empty tree
        far.mem[32'h0000_2000] = 32'h2040_0985;
        far.mem[32'h0000_2008] = 32'h0000_3000;
        far.mem[32'h0000_200C] = 32'h0000_0000;
        far.mem[32'h0000_3000] = 32'h0100_0000;
        far.mem[32'h0000_3004] = 32'h0000_4000;
        far.mem[32'h0000_3008] = 32'h0000_3010;
        far.mem[32'h0000_300C] = 32'h0000_403F;
        far.mem[32'h0000_3010] = 32'h0000_0000;
        far.mem[32'h0000_3014] = 32'h0000_5000;
        far.mem[32'h0000_3018] = 32'h0000_0000;
        far.mem[32'h0000_301C] = 32'h0000_500F;
        t_reset();
        t_frame();
        t_xfer();
        wrap_up();
    end
endmodule : tb_uhls_sched

//--- tb/uhls_far_model.sv
// Shared memory, packet engine and stream sink facing the scheduler.
// Assumes the bench preloads descriptors into mem before reset ends.
`timescale 1ns/1ps
module uhls_far_model (
    input  wire logic        ref_clk_i, rst_n_i,
    input  wire logic        mem_req_i, mem_we_i, pkt_req_i,
    input  wire logic [31:0] mem_addr_i, mem_wdata_i,
    output logic             mem_ack_o, pkt_done_o, dat_ready_o,
    output logic [31:0]      mem_rdata_o,
    output logic [3:0]       pkt_cc_o
);
    logic [31:0] mem [logic [31:0]];
    logic [1:0]  wait_q;
    logic [2:0]  pw_q;
    logic        slow_q;
    logic [3:0]  npkt_q;
    // Memory answers alternately at once and three cycles late
    always @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            {mem_ack_o, wait_q, slow_q} <= '0;
            mem_rdata_o <= 32'h0000_0000;
        end else if (mem_ack_o) begin
            mem_ack_o <= 1'b0;
            mem_rdata_o <= ~mem_rdata_o; // Released bus shows no stale word
        end else if (mem_req_i && wait_q != 2'h0) begin
            wait_q <= wait_q - 2'h1;
        end else if (mem_req_i) begin
            mem_ack_o <= 1'b1;
            slow_q <= ~slow_q;
            wait_q <= slow_q ? 2'h0 : 2'h3;
            if (mem_we_i) mem[mem_addr_i] = mem_wdata_i;
            mem_rdata_o <= mem.exists(mem_addr_i) ? mem[mem_addr_i] : 32'h0000_0000;
        end
    end
    // Packet engine: second packet ends with an error code
    always @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            {pkt_done_o, pw_q, npkt_q, dat_ready_o} <= '0;
            pkt_cc_o <= 4'h0;
        end else begin
            dat_ready_o <= ~dat_ready_o; // Stalls every other cycle
            pkt_done_o <= 1'b0;
            pkt_cc_o <= ~pkt_cc_o;
            pw_q <= pkt_req_i && !pkt_done_o ? pw_q + 3'h1 : 3'h0;
            if (pw_q == 3'h5) begin
                pkt_done_o <= 1'b1;
                pkt_cc_o <= npkt_q == 4'h1 ? 4'h5 : 4'h0;
                npkt_q <= npkt_q + 4'h1;
            end
        end
    end
endmodule : uhls_far_model

//--- tb/uhls_sched_checker.sv
// Port-level checks on the list scheduler.
// Assumes one clock and the active-low asynchronous reset.
`timescale 1ns/1ps
module uhls_sched_checker (
    input wire logic        ref_clk_i, rst_n_i,
    input wire logic [31:0] area_base_i, mem_addr_o, mem_wdata_o, dat_o,
    input wire logic        mem_req_o, mem_we_o, mem_ack_i, sof_o,
    input wire logic        pkt_req_o, pkt_done_i, pkt_toggle_o,
    input wire logic [6:0]  pkt_addr_o,
    input wire logic        dat_valid_o, dat_ready_i,
    input wire logic [15:0] frame_num_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);
    // Bus request and its qualifiers hold until acknowledged
    mem_hold_a: assert property (mem_req_o && !mem_ack_i |=> mem_req_o &&
        $stable(mem_addr_o) && $stable(mem_we_o) && $stable(mem_wdata_o))
        else $error("memory request changed before ack");
    mem_drop_a: assert property (mem_req_o && mem_ack_i |=> !mem_req_o)
        else $error("memory request not dropped after ack");
    // Packet request holds its address and toggle until done
    pkt_hold_a: assert property (pkt_req_o && !pkt_done_i |=> pkt_req_o &&
        $stable(pkt_addr_o) && $stable(pkt_toggle_o)) else $error("packet request changed");
    pkt_drop_a: assert property (pkt_req_o && pkt_done_i |=> !pkt_req_o)
        else $error("packet request not dropped after done");
    sof_pulse_a: assert property (sof_o |=> !sof_o)
        else $error("frame start longer than one cycle");
    sof_first_a: assert property (sof_o |-> !pkt_req_o)
        else $error("packet pending at frame start");
    // Frame number write follows each frame start
    fn_write_a: assert property (sof_o |-> ##[1:40] (mem_req_o && mem_we_o &&
        mem_addr_o == area_base_i + 32'h0000_0080)) else $error("frame number not written");
    fn_step_a: assert property ($changed(frame_num_o) |->
        frame_num_o == $past(frame_num_o) + 16'h0001) else $error("frame number skipped");
    // Interrupt head picked by low five frame bits
    int_pick_a: assert property (mem_req_o && !mem_we_o &&
        mem_addr_o - area_base_i < 32'h0000_0080 |->
        mem_addr_o - area_base_i == {25'h0, frame_num_o[4:0], 2'b00})
        else $error("wrong interrupt head read");
    dat_hold_a: assert property (dat_valid_o && !dat_ready_i |=> dat_valid_o && $stable(dat_o))
        else $error("stream word dropped under stall");
    cov_sof_c: cover property (sof_o);
    cov_pkt_c: cover property (pkt_req_o && pkt_done_i);
    cov_wr_c: cover property (mem_req_o && mem_we_o && mem_ack_i);
endmodule : uhls_sched_checker

bind uhls_sched uhls_sched_checker u_chk (.ref_clk_i, .rst_n_i, .area_base_i, .mem_addr_o,
    .mem_wdata_o, .dat_o, .mem_req_o, .mem_we_o, .mem_ack_i, .sof_o, .pkt_req_o,
    .pkt_done_i, .pkt_toggle_o, .pkt_addr_o, .dat_valid_o, .dat_ready_i, .frame_num_o);
